// file: src/sct_pkg.sv
// Package for the single-cycle core instruction timing decoder
package sct_pkg;
   // Timing of the core clock
   localparam int CLK_HZ      = 20000000;
   localparam int CYCLE_NS    = 50;
   // Reset values and the wait count limit
   localparam logic [15:0] PC_RST    = 16'h0000;
   localparam logic [3:0]  CNT_RST   = 4'h0;
   localparam logic [2:0]  WAIT_MAX  = 3'h7;
   // Base cycle counts
   localparam logic [3:0]  XMOVE_BASE = 4'h4;
   localparam logic [3:0]  LONG_CALL_IRQ = 4'h3;

   // Decoded length and timing of one opcode
   typedef struct packed {
      logic [1:0] bytes;
      logic [3:0] cycles;
      logic       branch;
      logic       xdata;
      logic       long_call;
      logic       known;
   } sct_timing_t;

   // Controller states
   typedef enum logic [1:0] {
      SCT_FETCH = 2'b01,
      SCT_EXEC  = 2'b10
   } sct_state_t;
endpackage

// file: src/sct_core_timing.sv
// Opcode length and cycle timing sequencer for a single-cycle core
`timescale 1ns/100ps
// Behaviour
// - Every counted cycle is exactly one core clock period.
// - External data moves are one byte, four cycles with zero waits.
// - With n wait states an external data move takes four plus n cycles.
// - Wait count ranges zero to seven, each step adds one cycle.
// - Long subroutine call is three bytes, four cycles normally.
// - Long subroutine call from an interrupt takes three cycles.
// - Both code byte moves are one byte, four cycles.
// - Indirect jump via accumulator plus data pointer: one byte, three cycles.
// - Two-byte relative branches take three cycles.
// - Three-byte conditional branches take four cycles.
// - Absolute calls/jumps two bytes three cycles; returns one byte four.
// - Register moves one cycle; indirect pointer moves two cycles; one byte.
// - Three-byte moves three cycles; two-byte moves two cycles.
// - Carry-only ops one byte one cycle; direct bit ops two bytes two.
// - Register exchange one cycle; indirect or nibble two; direct two/two.
// - Rotates and no-operation are one byte, one cycle.
// - Push and pop of a direct byte are two bytes, two cycles.
module sct_core_timing (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Opcode from program memory
   input  wire logic [7:0]  opcode,
   input  wire logic        opcode_valid,
   input  wire logic        irq_call,
   // Branch resolution from the execute unit
   input  wire logic        branch_taken,
   input  wire logic [15:0] branch_target,
   // External wait count setting
   input  wire logic [2:0]  external_wait_count,
   // Status toward the core
   output logic [15:0] pc,
   output logic        fetch_req,
   output logic        busy,
   output logic        done,
   output logic [3:0]  cycles_used,
   output logic [1:0]  length,
   output logic        illegal
);

   // Opcode groups handled by the table below
   // Register moves E8h-EFh and F8h-FFh, one cycle each
   // Indirect pointer moves E6h/E7h and F6h/F7h, two cycles each
   // Register exchange C8h-CFh, one cycle
   // Indirect exchange C6h/C7h and nibble exchange D6h/D7h, two cycles
   // Direct byte exchange C5h, two bytes and two cycles
   // Rotates 03h, 13h, 23h, 33h and no-operation 00h, one cycle
   // Carry-only ops C3h, D3h, B3h, one cycle
   // Direct bit ops C2h, D2h, B2h, 82h, B0h, 72h, A0h, A2h, 92h
   // Push C0h and pop D0h, two bytes and two cycles
   // Three-byte moves 85h, 75h, 90h, three cycles
   // Two-byte moves share the two-cycle slot with immediate forms
   // Code byte moves 83h and 93h, four cycles
   // External data moves E0h, E2h/E3h, F0h, F2h/F3h, four plus waits
   // Indirect jump 73h, three cycles
   // Returns 22h and 32h, four cycles
   // Absolute calls and jumps share low nibble 1h
   // Relative branches 80h, 40h, 50h, 60h, 70h and D8h-DFh
   // Long call 12h and long jump 02h, three bytes and four cycles
   // Three-byte conditionals 10h, 20h, 30h, D5h and B4h-BFh
   // Every other opcode is flagged unknown and timed as one cycle
   // Order of the tests matters: narrow matches come first
   // Absolute forms are tested by low nibble only, so they sit late
   // Hazard: no opcode matched above has a 1h low nibble, so moving the nibble test up
   // is harmless today but would hide later additions with a 1h low nibble
   // Length and cycle table by opcode
   function automatic sct_pkg::sct_timing_t decode(input logic [7:0] op);
      sct_pkg::sct_timing_t t;
      // Default: one byte, one cycle, not a branch
      t = '{bytes: 2'd1, cycles: 4'd1, branch: 1'b0, xdata: 1'b0, long_call: 1'b0,
            known: 1'b1};
      if (op[7:3] == 5'b11101 || op[7:3] == 5'b11111) t.cycles = 4'd1;
      else if (op[7:1] == 7'b1110011 || op[7:1] == 7'b1111011) t.cycles = 4'd2;
      else if (op[7:3] == 5'b11001) t.cycles = 4'd1;
      else if (op[7:1] == 7'b1100011 || op[7:1] == 7'b1101011) t.cycles = 4'd2;
      else if (op == 8'hC5) begin
         t.bytes  = 2'd2;
         t.cycles = 4'd2;
      end
      else if (op == 8'h00 || op == 8'h03 || op == 8'h13 || op == 8'h23 ||
               op == 8'h33) t.cycles = 4'd1;
      else if (op == 8'hC3 || op == 8'hD3 || op == 8'hB3) t.cycles = 4'd1;
      else if (op == 8'hC2 || op == 8'hD2 || op == 8'hB2 || op == 8'h82 ||
               op == 8'hB0 || op == 8'h72 || op == 8'hA0 || op == 8'hA2 ||
               op == 8'h92) begin
         t.bytes  = 2'd2;
         t.cycles = 4'd2;
      end
      else if (op == 8'hC0 || op == 8'hD0) begin
         t.bytes  = 2'd2;
         t.cycles = 4'd2;
      end
      else if (op == 8'h85 || op == 8'h75 || op == 8'h90) begin
         t.bytes  = 2'd3;
         t.cycles = 4'd3;
      end
      else if (op == 8'hE5 || op == 8'h74 || op[7:3] == 5'b01111 ||
               op == 8'hF5 || op[7:3] == 5'b10101 || op[7:3] == 5'b10001 ||
               op[7:1] == 7'b0111011 || op[7:1] == 7'b1000011 ||
               op[7:1] == 7'b1010011) begin
         t.bytes  = 2'd2;
         t.cycles = 4'd2;
      end
      else if (op == 8'h93 || op == 8'h83) t.cycles = 4'd4;
      else if (op == 8'hE0 || op == 8'hF0 || op[7:1] == 7'b1110001 ||
               op[7:1] == 7'b1111001) begin
         t.cycles = sct_pkg::XMOVE_BASE;
         t.xdata  = 1'b1;
      end
      else if (op == 8'h73) begin
         t.cycles = 4'd3;
         t.branch = 1'b1;
      end
      else if (op == 8'h22 || op == 8'h32) begin
         t.cycles = 4'd4;
         t.branch = 1'b1;
      end
      else if (op[3:0] == 4'h1) begin
         t.bytes  = 2'd2;
         t.cycles = 4'd3;
         t.branch = 1'b1;
      end
      else if (op == 8'h80 || op == 8'h40 || op == 8'h50 || op == 8'h60 ||
               op == 8'h70 || op[7:3] == 5'b11011) begin
         t.bytes  = 2'd2;
         t.cycles = 4'd3;
         t.branch = 1'b1;
      end
      // long call, long jump shares its timing
      else if (op == 8'h12 || op == 8'h02) begin
         t.bytes  = 2'd3;
         t.cycles = 4'd4;
         t.branch = 1'b1;
         t.long_call = (op == 8'h12);
      end
      else if (op == 8'h20 || op == 8'h30 || op == 8'h10 || op == 8'hD5 ||
               op[7:4] == 4'hB && op[3:0] >= 4'h4) begin
         t.bytes  = 2'd3;
         t.cycles = 4'd4;
         t.branch = 1'b1;
      end
      // Arithmetic and logic opcodes: treated as one byte, one cycle
      else t.known = 1'b0;
      return t;
   endfunction

   // Sequencer state and the record of the running instruction
   // The count starts at one on the take edge, so a target of N
   // ends the instruction after exactly N clocks
   sct_pkg::sct_state_t  state_ff, nxt_state;
   sct_pkg::sct_timing_t cur_ff, nxt_cur;
   logic [3:0]  cnt_ff, nxt_cnt;
   logic [3:0]  tgt_ff, nxt_tgt;
   logic [15:0] pc_ff, nxt_pc;
   logic        done_ff, nxt_done;
   logic [3:0]  used_ff, nxt_used;
   logic [1:0]  len_ff, nxt_len;
   logic        ill_ff, nxt_ill;
   sct_pkg::sct_timing_t dec;
   logic [3:0]  target;

   // Decode and target cycle count
   always_comb begin
      dec    = decode(opcode);
      target = dec.cycles;
      // add wait states to external moves
      // zero to seven waits, one cycle each
      if (dec.xdata)
         target = sct_pkg::XMOVE_BASE + {1'b0, external_wait_count};
      // interrupt-issued long call
      // Only the long call opcode is shortened, never the long jump
      if (dec.long_call && irq_call)
         target = sct_pkg::LONG_CALL_IRQ;
   end

   // Sequencer next state
   // FETCH takes an opcode when one is offered
   // One-cycle opcodes finish on the take edge and stay in FETCH,
   // so a new opcode may follow on the very next edge
   // Longer opcodes move to EXEC and count one per clock
   // Opcodes offered while in EXEC are ignored
   // The done pulse, length and cycle figures change together
   always_comb begin
      nxt_state = state_ff;
      nxt_cur   = cur_ff;
      nxt_cnt   = cnt_ff;
      nxt_tgt   = tgt_ff;
      nxt_pc    = pc_ff;
      nxt_done  = 1'b0;
      nxt_used  = used_ff;
      nxt_len   = len_ff;
      nxt_ill   = ill_ff;
      unique case (state_ff)
         sct_pkg::SCT_FETCH: begin
            if (opcode_valid) begin
               nxt_cur = dec;
               nxt_tgt = target;
               nxt_ill = ~dec.known;
               // first cycle of the instruction
               // The take edge itself is the first counted cycle
               nxt_cnt = 4'h1;
               if (target == 4'h1) begin
                  nxt_pc   = pc_ff + {14'h0000, dec.bytes};
                  nxt_done = 1'b1;
                  nxt_used = target;
                  nxt_len  = dec.bytes;
               end else begin
                  nxt_state = sct_pkg::SCT_EXEC;
               end
            end
         end
         sct_pkg::SCT_EXEC: begin
            nxt_cnt = cnt_ff + 4'h1;
            if (nxt_cnt == tgt_ff) begin
               nxt_state = sct_pkg::SCT_FETCH;
               nxt_done  = 1'b1;
               nxt_used  = tgt_ff;
               nxt_len   = cur_ff.bytes;
               // advance PC by length
               // Branch outcome is sampled on the last cycle only
               // A not-taken branch advances like any other opcode
               if (cur_ff.branch && branch_taken) begin
                  nxt_pc = branch_target;
               end else begin
                  nxt_pc = pc_ff + {14'h0000, cur_ff.bytes};
               end
            end
         end
         default: nxt_state = sct_pkg::SCT_FETCH;
      endcase
   end

   // Sequencer registers
   // Reset puts the sequencer in FETCH with all figures cleared
   // Only constants are loaded in the reset branch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= sct_pkg::SCT_FETCH;
         cur_ff   <= '0;
         cnt_ff   <= sct_pkg::CNT_RST;
         tgt_ff   <= sct_pkg::CNT_RST;
         pc_ff    <= sct_pkg::PC_RST;
         done_ff  <= 1'b0;
         used_ff  <= sct_pkg::CNT_RST;
         len_ff   <= 2'd0;
         ill_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cur_ff   <= nxt_cur;
         cnt_ff   <= nxt_cnt;
         tgt_ff   <= nxt_tgt;
         pc_ff    <= nxt_pc;
         done_ff  <= nxt_done;
         used_ff  <= nxt_used;
         len_ff   <= nxt_len;
         ill_ff   <= nxt_ill;
      end
   end

   // Outputs
   // Handshake flags decode the state directly
   // Data outputs come straight from flip-flops
   assign pc          = pc_ff;
   assign fetch_req   = (state_ff == sct_pkg::SCT_FETCH);
   assign busy        = (state_ff == sct_pkg::SCT_EXEC);
   assign done        = done_ff;
   assign cycles_used = used_ff;
   assign length      = len_ff;
   assign illegal     = ill_ff;

endmodule

// file: verif/sct_core_timing_chk.sv
// Timing checker bound to the core timing sequencer
`timescale 1ns/100ps
module sct_core_timing_chk (
   // Core side
   input wire logic        clk, rst_n, opcode_valid, irq_call, branch_taken, fetch_req, done,
   input wire logic [7:0]  opcode,
   input wire logic [2:0]  external_wait_count,
   input wire logic [15:0] branch_target, pc,
   input wire logic [3:0]  cycles_used,
   input wire logic [1:0]  length
);
   logic        tk, xm;
   logic [23:0] hs_ff, nxt_hs;
   // Take strobe and external move decode
   assign tk = fetch_req && opcode_valid;
   assign xm = opcode[7:5] == 3'h7 && (opcode[3:0] == 4'h0 || opcode[3:1] == 3'h1);
   // Clocks since take, pc at take, expected external move cycles
   always_comb nxt_hs = tk ? {4'h1, pc, xm ? 4'h4 + {1'b0, external_wait_count} : 4'h0}
                           : {hs_ff[23:20] + 4'h1, hs_ff[19:0]};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) hs_ff <= 24'h000000;
      else hs_ff <= nxt_hs;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Ends of instructions
   AST_CNT: assert property (done |-> cycles_used == hs_ff[23:20])
      else $error("cycle count");
   AST_XWAIT: assert property (done && hs_ff[3:0] != 4'h0 |-> cycles_used == hs_ff[3:0])
      else $error("external move");
   AST_LONG_CALL: assert property (
      tk && opcode == 8'h12 && !irq_call |=> !done [*3] ##1 done && length == 2'h3)
      else $error("long call");
   AST_ICALL: assert property (
      tk && opcode == 8'h12 && irq_call |=> !done [*2] ##1 done && cycles_used == 4'h3)
      else $error("interrupt call");
   AST_NOP: assert property (tk && opcode == 8'h00 |=> done && cycles_used == 4'h1)
      else $error("no-operation");
   AST_PC: assert property (
      done && !$past(branch_taken) |-> pc == hs_ff[19:4] + {14'h0000, length})
      else $error("pc advance");
   AST_TGT: assert property (done && $past(branch_taken) |-> pc == $past(branch_target))
      else $error("branch target");
   AST_NEXT: assert property (done |-> fetch_req)
      else $error("fetch after end");
endmodule
bind sct_core_timing sct_core_timing_chk CHK (.*);

// file: verif/sct_prog_mem.sv
// Program memory model presenting opcode bytes to the core
`timescale 1ns/100ps
module sct_prog_mem (
   // Core side
   input  wire logic        clk, en,
   input  wire logic [15:0] pc,
   output      logic [7:0]  opcode,
   output      logic        opcode_valid
);
   logic [7:0] mem [256];
   logic [7:0] last_ff = 8'h00;
   // Released bus shows the inverse of the last byte
   assign opcode = en ? mem[pc[7:0]] : ~last_ff;
   assign opcode_valid = en;
   always @(posedge clk) if (en) last_ff <= mem[pc[7:0]];
endmodule

// file: verif/test_single_cycle_core_instruction_timing.sv
// Self-checking bench for the core timing sequencer
`timescale 1ns/100ps
module test_single_cycle_core_instruction_timing;
   logic        clk = 1'b0, rst_n = 1'b0, en = 1'b0, irq_call = 1'b0, branch_taken = 1'b0;
   logic        opcode_valid, fetch_req, busy, done, illegal;
   logic [15:0] pc, branch_target = 16'h0040;
   logic [7:0]  opcode;
   logic [3:0]  cycles_used;
   logic [2:0]  external_wait_count = 3'h0;
   logic [1:0]  length;
   int          miscompares = 0, comparisons = 0;
   // Opcode, bytes, cycles of the listed forms
   localparam logic [15:0] TBL [40] = '{16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'h0011,
      16'hE811, 16'hE612, 16'hF612, 16'hF811, 16'h8533, 16'h7533, 16'h9033, 16'hE522,
      16'h7422, 16'h7822, 16'hF522, 16'hA822, 16'h8822, 16'h7622, 16'h8622, 16'hA622,
      16'h9314, 16'h8314, 16'hC022, 16'hD022, 16'hC811, 16'hC612, 16'hD612, 16'hC522,
      16'hC311, 16'hB222, 16'hA022, 16'h7313, 16'h2214, 16'h3214, 16'h1123, 16'h0123,
      16'h8023, 16'hD823, 16'h1234};
   always #25 clk = ~clk;
   sct_core_timing DUT (.*);
   sct_prog_mem PM (.*);
   task automatic summarize;
      $display("errors %0d of %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, g);
      comparisons++;
      if (g !== e) $display("[ERR] %s exp %h got %h", nm, e, g);
      if (g !== e) miscompares++;
   endtask
   // Runs one instruction and judges its end
   task automatic ex(input logic [7:0] op, input logic [3:0] c, input logic [1:0] b,
                     input logic [2:0] w = 3'h0, input logic q = 1'b0, t = 1'b0, il = 1'b0);
      logic [15:0] p;
      int n;
      p = pc;
      PM.mem[pc[7:0]] = op;
      external_wait_count = w;
      irq_call = q;
      branch_taken = t;
      en = 1'b1;
      @(negedge clk);
      en = 1'b0;
      for (n = 1; done !== 1'b1 && n < 20; n++) @(negedge clk);
      chk("clocks", 16'(c), 16'(n));
      chk("len_cyc", {10'h000, b, c}, {10'h000, length, cycles_used});
      chk("pc", t ? branch_target : p + 16'(b), pc);
      chk("illegal", 16'(il), 16'(illegal));
      if (n >= 20) summarize();
      @(negedge clk);
   endtask
   task automatic t_table;
      for (int i = 0; i < 40; i++) ex(TBL[i][15:8], TBL[i][3:0], TBL[i][5:4]);
   endtask
   task automatic t_waits;
      for (int i = 0; i < 8; i++) ex(i[0] ? 8'hF2 : 8'hE0, 4'h4 + 4'(i), 2'h1, 3'(i));
   endtask
   // Taken branches, interrupt call and an unlisted opcode
   task automatic t_flow;
      ex(8'h80, 4'h3, 2'h2, 3'h0, 1'b0, 1'b1);
      ex(8'h10, 4'h4, 2'h3, 3'h0, 1'b0, 1'b1);
      ex(8'h12, 4'h3, 2'h3, 3'h0, 1'b1, 1'b1);
      ex(8'h12, 4'h3, 2'h3, 3'h2, 1'b1);
      ex(8'h24, 4'h1, 2'h1, 3'h0, 1'b0, 1'b0, 1'b1);
   endtask
   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      t_table();
      t_waits();
      t_flow();
      summarize();
   end
endmodule
